// ### hw/cgt_defs.svh
// Purpose: Constants for the channel 2 gain trim and map checksum register slice
// Assumes: Registers are reached over APB, one aligned 32-bit word per register
// Notes:   Printed offsets are register indices; byte address is four times the index
//
// Summary of operation
// - Gain trim bits 23:8 live in the full 16-bit register 16h, read/write.
// - Register 16h resets to 8000h, only its top bit set.
// - Gain trim bits 7:0 live in bits 15:8 of register 17h, read/write.
// - Register 17h resets to 0000h; its low byte reads zero, ignores writes.
// - Register 3Eh is a read-only 16-bit map checksum reading 0000h after reset.
`ifndef CGT_DEFS_SVH
`define CGT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define CGT_IDX_TRIM_HIGH   8'h16
`define CGT_IDX_TRIM_LOW    8'h17
`define CGT_IDX_CHECKSUM    8'h3e
`define CGT_IDX_RSVD_LAST   8'h3f
`define CGT_ADDR_W          10
`define CGT_ADDR_LSB        2

// ----------------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------------
`define CGT_RST_TRIM_HIGH   16'h8000
`define CGT_RST_TRIM_LOW    8'h00
`define CGT_RST_CHECKSUM    16'h0000
`define CGT_RST_RSVD_LAST   16'h0000
`define CGT_LOW_FIELD_MSB   15
`define CGT_LOW_FIELD_LSB   8

// ----------------------------------------------------------------------------
// Checksum polynomial and seed
// ----------------------------------------------------------------------------
`define CGT_CRC_POLY        16'h1021
`define CGT_CRC_SEED        16'hffff

`endif

// ### hw/cgt_pkg.sv
// Purpose: Types shared by the gain trim register slice
// Assumes: Constants come from cgt_defs.svh
// Notes:   Types only, no numbers of their own
`include "cgt_defs.svh"

package cgt_pkg;

    // ------------------------------------------------------------------------
    // APB request as seen by the slave
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                   sel;
        logic                   enable;
        logic                   write;
        logic [`CGT_ADDR_W-1:0] addr;
        logic [31:0]            wdata;
        logic [3:0]             strb;
    } cgt_apb_req_t;

    // Register map contents that the checksum covers
    typedef struct packed {
        logic [15:0] trim_high;
        logic [7:0]  trim_low;
        logic [15:0] rsvd_last;
    } cgt_map_t;

    // State of the checksum unit
    typedef struct packed {
        logic [15:0] crc;
    } cgt_crc_state_t;

    // State of the register slave
    typedef struct packed {
        logic [15:0] trim_high;
        logic [7:0]  trim_low;
        logic [15:0] rsvd_last;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        update;
        logic        written;
        logic        settled;
    } cgt_state_t;

endpackage : cgt_pkg

// ### hw/cgt_checksum.sv
// Purpose: Register map checksum, recomputed whenever the map changes
// Assumes: update is a one-cycle pulse one cycle after a committed write
// Notes:   Holds its reset value until the first update pulse
`timescale 1ns/1ps
`include "cgt_defs.svh"

module cgt_checksum
    import cgt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        update,
    input  wire cgt_map_t    map,
    output logic [15:0]      crc_ff
);

    // ------------------------------------------------------------------------
    // Bitwise CRC over the packed map, MSB first
    // ------------------------------------------------------------------------
    function automatic logic [15:0] crc16(input cgt_map_t m);
        logic [15:0] c;
        logic [$bits(cgt_map_t)-1:0] d;
        c = `CGT_CRC_SEED;
        d = m;
        for (int i = $bits(cgt_map_t) - 1; i >= 0; i--) begin
            if (c[15] ^ d[i]) begin
                c = {c[14:0], 1'b0} ^ `CGT_CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction

    cgt_crc_state_t st_ff;
    cgt_crc_state_t nxt_st;

    // Recompute only on update so a read never sees a half-changed map
    always_comb begin
        nxt_st = st_ff;
        if (update) begin
            nxt_st.crc = crc16(map);
        end
    end

    // Zero until the first update so the reset value reads 0000h
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff.crc <= `CGT_RST_CHECKSUM;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign crc_ff = st_ff.crc;

endmodule // cgt_checksum

// ### hw/cgt_regs.sv
// Purpose: APB slave holding channel 2 gain trim, map checksum and last reserved slot
// Assumes: APB master on CLK; one wait state on every transfer
// Notes:   Unmapped addresses answer with PSLVERR and zero read data
`timescale 1ns/1ps
`include "cgt_defs.svh"

module cgt_regs
    import cgt_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   RESET_N,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [`CGT_ADDR_W-1:0] PADDR,
    input  wire logic [31:0]            PWDATA,
    input  wire logic [3:0]             PSTRB,
    output logic                        PREADY,
    output logic [31:0]                 PRDATA,
    output logic                        PSLVERR,
    output logic [23:0]                 GAIN_TRIM,
    output logic [15:0]                 MAP_CHECKSUM
);

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        CGT_SEL_HIGH,
        CGT_SEL_LOW,
        CGT_SEL_CRC,
        CGT_SEL_RSVD,
        CGT_SEL_NONE
    } cgt_sel_t;

    // Byte address is four times the index; misaligned falls to none
    function automatic cgt_sel_t decode(input logic [`CGT_ADDR_W-1:0] a);
        cgt_sel_t s;
        s = CGT_SEL_NONE;
        if (a[`CGT_ADDR_LSB-1:0] == 2'h0) begin
            unique case (a[`CGT_ADDR_W-1:`CGT_ADDR_LSB])
                `CGT_IDX_TRIM_HIGH: s = CGT_SEL_HIGH;
                `CGT_IDX_TRIM_LOW:  s = CGT_SEL_LOW;
                `CGT_IDX_CHECKSUM:  s = CGT_SEL_CRC;
                `CGT_IDX_RSVD_LAST: s = CGT_SEL_RSVD;
                default:            s = CGT_SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // Merge a 16-bit register with write data under byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sb);
        logic [15:0] r;
        r = old;
        if (sb[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sb[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // State and bus request
    // ------------------------------------------------------------------------
    cgt_state_t   st_ff;
    cgt_state_t   nxt_st;
    cgt_apb_req_t req;
    cgt_map_t     map;
    cgt_sel_t     sel;
    logic [15:0]  crc_ff;
    logic         access;
    logic         commit;

    assign req.sel    = PSEL;
    assign req.enable = PENABLE;
    assign req.write  = PWRITE;
    assign req.addr   = PADDR;
    assign req.wdata  = PWDATA;
    assign req.strb   = PSTRB;

    assign sel    = decode(req.addr);
    assign access = req.sel & req.enable;
    // The master samples PREADY high on this edge, so the write lands here
    assign commit = access & st_ff.pready;

    // Read mux; the low byte of the low trim register is always zero
    function automatic logic [31:0] read_word(input cgt_sel_t s,
                                              input cgt_state_t q,
                                              input logic [15:0] c);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (s)
            CGT_SEL_HIGH: r = {16'h0000, q.trim_high};
            CGT_SEL_LOW:  r = {16'h0000, q.trim_low, 8'h00};
            CGT_SEL_CRC:  r = {16'h0000, c};
            CGT_SEL_RSVD: r = {16'h0000, q.rsvd_last};
            CGT_SEL_NONE: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // One wait state keeps read data and PREADY both registered
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.update  = 1'b0;
        nxt_st.settled = 1'b1;
        nxt_st.pready  = 1'b0;
        nxt_st.pslverr = 1'b0;
        if (access && !st_ff.pready) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = (sel == CGT_SEL_NONE);
            nxt_st.prdata  = req.write ? 32'h0000_0000 : read_word(sel, st_ff, crc_ff);
        end
        if (commit) begin
            nxt_st.prdata = 32'h0000_0000;
        end
        if (commit && req.write) begin
            unique case (sel)
                CGT_SEL_HIGH: begin
                    nxt_st.trim_high = merge16(st_ff.trim_high, req.wdata, req.strb);
                end
                CGT_SEL_LOW: begin
                    // Only the upper byte is stored; the lower byte drops writes
                    if (req.strb[1]) begin
                        nxt_st.trim_low =
                            req.wdata[`CGT_LOW_FIELD_MSB:`CGT_LOW_FIELD_LSB];
                    end
                end
                CGT_SEL_RSVD: begin
                    // Stored as written; software keeps it at zero
                    nxt_st.rsvd_last = merge16(st_ff.rsvd_last, req.wdata, req.strb);
                end
                CGT_SEL_CRC: begin
                    // Read only: write is acknowledged and dropped
                    nxt_st.rsvd_last = st_ff.rsvd_last;
                end
                CGT_SEL_NONE: begin
                    nxt_st.rsvd_last = st_ff.rsvd_last;
                end
            endcase
            if (sel != CGT_SEL_NONE && sel != CGT_SEL_CRC) begin
                nxt_st.update  = 1'b1;
                nxt_st.written = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff.trim_high <= `CGT_RST_TRIM_HIGH;
            st_ff.trim_low  <= `CGT_RST_TRIM_LOW;
            st_ff.rsvd_last <= `CGT_RST_RSVD_LAST;
            st_ff.pready    <= 1'b0;
            st_ff.prdata    <= 32'h0000_0000;
            st_ff.pslverr   <= 1'b0;
            st_ff.update    <= 1'b0;
            st_ff.written   <= 1'b0;
            st_ff.settled   <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------------
    // Checksum unit
    // ------------------------------------------------------------------------
    // Map is sampled the cycle after the write, when it is stable
    assign map.trim_high = st_ff.trim_high;
    assign map.trim_low  = st_ff.trim_low;
    assign map.rsvd_last = st_ff.rsvd_last;

    cgt_checksum u_checksum (
        .clk     (CLK),
        .reset_n (RESET_N),
        .update  (st_ff.update),
        .map     (map),
        .crc_ff  (crc_ff)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign PREADY       = st_ff.pready;
    assign PRDATA       = st_ff.prdata;
    assign PSLVERR      = st_ff.pslverr;
    assign GAIN_TRIM    = {st_ff.trim_high, st_ff.trim_low};
    assign MAP_CHECKSUM = crc_ff;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // Setup then access with the request held
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence

    sequence s_hi_write;
        commit && PWRITE && sel == CGT_SEL_HIGH && PSTRB[1:0] == 2'h3;
    endsequence

    sequence s_lo_write;
        commit && PWRITE && sel == CGT_SEL_LOW && PSTRB[1];
    endsequence

    // PREADY rises exactly one cycle into the access phase
    bus_wait_state_a: assert property (s_setup ##1 s_access |=> PREADY)
        else $error("PREADY not raised after one wait state");

    // High trim takes the full word written
    hi_write_a: assert property (s_hi_write |=> st_ff.trim_high == $past(PWDATA[15:0]))
        else $error("High gain trim did not take write data");

    // High trim holds its reset value until the map is first written
    hi_reset_a: assert property (!st_ff.written |-> st_ff.trim_high == 16'h8000)
        else $error("High gain trim lost its reset value");

    // Low trim field is taken from bits 15:8
    lo_write_a: assert property (s_lo_write |=> st_ff.trim_low == $past(PWDATA[15:8]))
        else $error("Low gain trim did not take upper byte");

    // Read of low trim gives zero in the low byte and reset value zero
    lo_read_a: assert property (PREADY && !PSLVERR && $past(sel) == CGT_SEL_LOW
                                && !$past(PWRITE) |-> PRDATA[7:0] == 8'h00
                                && (st_ff.written || PRDATA[15:8] == 8'h00))
        else $error("Low gain trim reserved byte not zero");

    // Checksum reads zero until the map is first written, then follows it in two cycles
    crc_reset_a: assert property (!st_ff.written && !$past(st_ff.written)
                                  |-> crc_ff == 16'h0000)
        else $error("Checksum not zero after reset");

    crc_follow_a: assert property (s_hi_write |-> ##2 crc_ff != $past(crc_ff, 2)
                                   || $past(st_ff.trim_high, 2) == st_ff.trim_high)
        else $error("Checksum did not follow a map change");

    // Gain word follows a low trim write in the next cycle
    gain_join_a: assert property (s_lo_write |=> GAIN_TRIM[7:0] == $past(PWDATA[15:8])
                                  && GAIN_TRIM[23:8] == st_ff.trim_high)
        else $error("Gain trim word not formed from both registers");

endmodule // cgt_regs

// ### tb/cgt_regs_bench.sv
// Purpose: Self-checking bench for the channel 2 gain trim and map checksum registers
// Assumes: Bench is the only APB master; one clock, reset held low for 20 cycles
// Notes:   Driver queues each expected answer, a monitor pops it when PREADY shows
`timescale 1ns/1ps
`include "cgt_defs.svh"

module cgt_regs_bench;

    // ------------------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------------------
    logic                   clk;
    logic                   reset_n;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`CGT_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
    logic [3:0]             pstrb;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
    logic [23:0]            gain_trim;
    logic [15:0]            map_checksum;
    int                     fails;
    int                     n_tests;
    integer                 seed;
    logic [31:0]            v;
    logic [33:0]            exp_q[$];
    logic [33:0]            mon_e;
    logic [15:0]            m_hi;
    logic [7:0]             m_lo;
    logic [15:0]            m_rsv;
    logic                   m_seen;

    cgt_regs u_dut (
        .CLK          (clk),
        .RESET_N      (reset_n),
        .PSEL         (psel),
        .PENABLE      (penable),
        .PWRITE       (pwrite),
        .PADDR        (paddr),
        .PWDATA       (pwdata),
        .PSTRB        (pstrb),
        .PREADY       (pready),
        .PRDATA       (prdata),
        .PSLVERR      (pslverr),
        .GAIN_TRIM    (gain_trim),
        .MAP_CHECKSUM (map_checksum)
    );

    // Free-running 10 MHz clock
    always #50 clk = ~clk;

    // ------------------------------------------------------------------------
    // Comparison, expected checksum and closing
    // ------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // CRC-16, MSB first; kept apart from the design so a shared slip cannot hide
    function automatic logic [15:0] crc_of(input logic [39:0] d);
        logic [15:0] c;
        logic        fb;
        c = 16'hffff;
        for (int i = 39; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c  = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction

    function automatic logic [15:0] exp_csum();
        return m_seen ? crc_of({m_hi, m_lo, m_rsv}) : 16'h0000;
    endfunction

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // APB master tasks; entered just after a rising edge
    // ------------------------------------------------------------------------
    // Leaves the bus selected so another transfer may follow at once
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                       input logic [3:0] sb, input logic [31:0] rd, input logic err);
        exp_q.push_back({~wr, err, rd});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= sb;
        @(posedge clk);
        penable <= 1'b1;
        // No local limit: a slave that never answers is caught by the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
    endtask

    task automatic idle(input int n);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    // Write and update the bench's view of the registers
    task automatic wr(input logic [9:0] a, input logic [31:0] wd, input logic [3:0] sb);
        logic err;
        err = !(a == 10'h058 || a == 10'h05c || a == 10'h0f8 || a == 10'h0fc);
        apb(1'b1, a, wd, sb, 32'h0, err);
        if (a == 10'h058 || a == 10'h05c || a == 10'h0fc)
            m_seen = 1'b1;
        if (a == 10'h058 && sb[0]) m_hi[7:0] = wd[7:0];
        if (a == 10'h058 && sb[1]) m_hi[15:8] = wd[15:8];
        if (a == 10'h05c && sb[1]) m_lo = wd[15:8];
        if (a == 10'h0fc && sb[0]) m_rsv[7:0] = wd[7:0];
        if (a == 10'h0fc && sb[1]) m_rsv[15:8] = wd[15:8];
    endtask

    task automatic rd(input logic [9:0] a);
        logic [31:0] e;
        e = 32'h0;
        case (a)
            10'h058: e = {16'h0, m_hi};
            10'h05c: e = {16'h0, m_lo, 8'h00};
            10'h0f8: e = {16'h0, exp_csum()};
            10'h0fc: e = {16'h0, m_rsv};
            default: e = 32'h0;
        endcase
        apb(1'b0, a, 32'h0, 4'h0, e, !(a == 10'h058 || a == 10'h05c ||
                                      a == 10'h0f8 || a == 10'h0fc));
    endtask

    // ------------------------------------------------------------------------
    // Monitor: each answer is matched against the oldest note
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (reset_n === 1'b1 && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("unexpected at %0t: answer with nothing pending", $time);
            end else begin
                mon_e = exp_q.pop_front();
                check({31'h0, pslverr}, {31'h0, mon_e[32]});
                if (mon_e[33]) check(prdata, mon_e[31:0]);
            end
        end
    end

    // Watchdog, well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        $display("unexpected at %0t: run timed out", $time);
        complete_run();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        seed = 32'he87f;
        clk = 1'b0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = 32'h0; pstrb = 4'h0; fails = 0; n_tests = 0;
        m_hi = 16'h8000; m_lo = 8'h00; m_rsv = 16'h0000; m_seen = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // Reset values at the outputs and in every register
        check({8'h0, gain_trim}, 32'h00800000);
        check({16'h0, map_checksum}, 32'h0);
        rd(10'h058); rd(10'h05c); rd(10'h0f8); rd(10'h0fc);
        // Random trims, each read back in the very next transfer
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            wr(10'h058, v, 4'hf); rd(10'h058);
            v = $random(seed);
            wr(10'h05c, v, 4'hf); rd(10'h05c);
            idle(3);
            check({8'h0, gain_trim}, {8'h0, m_hi, m_lo});
            check({16'h0, map_checksum}, {16'h0, exp_csum()});
            rd(10'h0f8);
        end
        // Single byte lanes; low byte of the low register must stay zero
        wr(10'h058, 32'h0000a55a, 4'b0001); wr(10'h058, 32'h00003cc3, 4'b0010);
        wr(10'h05c, 32'h0000ffff, 4'b0001); rd(10'h058); rd(10'h05c);
        // Reserved slot gets zeros only; a write to the checksum is dropped
        wr(10'h0fc, 32'h0, 4'hf);
        v = $random(seed);
        wr(10'h0f8, v, 4'hf); idle(3); rd(10'h0f8); rd(10'h0fc);
        idle(1);
        check({16'h0, map_checksum}, {16'h0, exp_csum()});
        // Unmapped and misaligned places answer with an error, no effect
        rd(10'h040); wr(10'h059, v, 4'hf); rd(10'h05a); wr(10'h3fc, v, 4'hf);
        idle(3); rd(10'h058); rd(10'h05c); idle(3);
        check({8'h0, gain_trim}, {8'h0, m_hi, m_lo});
        // Mid-run reset must bring every written register back to its reset value
        reset_n <= 1'b0;
        m_hi = 16'h8000; m_lo = 8'h00; m_rsv = 16'h0000; m_seen = 1'b0;
        idle(2);
        reset_n <= 1'b1;
        @(posedge clk);
        check({8'h0, gain_trim}, 32'h00800000);
        check({16'h0, map_checksum}, 32'h0);
        rd(10'h058); rd(10'h05c); rd(10'h0f8); rd(10'h0fc); idle(3);
        check(exp_q.size(), 32'h0);
        complete_run();
    end

endmodule // cgt_regs_bench
